/* core/poeoc_top.sv */
// Per-port overload and hard-limit timeout supervision for four powered ports.
`timescale 1ns/1ps

// Behaviour
// - Overload reached outside inrush: count down, power off at zero
// - Below overload: slow count up, saturate at field
// - Low codes select 374,110,204,374 mA
// - High codes select 754,592,645,920 mA
// - Auto mode derives settings from classification
// - Powered, good: plus-power picks doubled curve
// - Inrush limit ignores plus-power select
// - Hard limit reached: count down, power off
// - Hard limit cleared: slow count up, saturate
// - Short circuit: gate off at once
// - Overload expiry sets overload fault flag
// - Hard-limit expiry sets hard-limit fault flag
module poeoc_top #(
    parameter int PORTS_P   = poeoc_pkg::PORTS,        // Number of ports
    parameter int UP_RATIO_P = poeoc_pkg::UP_RATIO     // Decrement ticks per increment
) (
    input  wire logic                          sys_clk,        // 10 MHz clock
    input  wire logic                          resetn,         // Async reset, low
    input  wire logic [poeoc_pkg::ADDR_W-1:0]  reg_addr,       // Register address
    input  wire logic [poeoc_pkg::DATA_W-1:0]  reg_wdata,      // Write data
    input  wire logic                          reg_wr,         // Write strobe
    input  wire logic                          reg_rd,         // Read strobe
    output logic      [poeoc_pkg::DATA_W-1:0]  reg_rdata,      // Read data, next cycle
    input  wire logic [PORTS_P-1:0]            port_current_ma_valid, // Measurement valid
    input  wire logic [PORTS_P*10-1:0]         port_current_ma,// Port current in mA
    input  wire logic [PORTS_P-1:0]            hard_limit_hit, // Foldback limit reached
    input  wire logic [PORTS_P-1:0]            short_detect,   // Short circuit comparator
    input  wire logic [PORTS_P-1:0]            power_good,     // Power good per port
    input  wire logic [PORTS_P-1:0]            inrush_active,  // Start period running
    input  wire logic [PORTS_P-1:0]            class_plus,     // Class result: type 2 device
    input  wire logic [PORTS_P-1:0]            class_valid,    // Classification done
    output logic      [PORTS_P-1:0]            port_power_en,  // Port powered
    output logic      [PORTS_P-1:0]            gate_force_off, // Pass gate pulled off
    output logic      [PORTS_P-1:0]            limit_curve_2x, // Doubled foldback curve
    output logic      [PORTS_P-1:0]            limit_inrush,   // Inrush profile selected
    output logic                               low_sense_resistor_select // Sense scale
);
    import poeoc_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [2:0]         thr_code_q [PORTS_P];    // Host threshold codes
    logic [PORTS_P-1:0] plus_q;                  // Host plus-power selects
    logic [3:0]         tim_ovl_q;               // Overload timeout field
    logic [3:0]         tim_lim_q;               // Hard-limit timeout field
    logic               auto_q;                  // Automatic mode
    logic               lsr_q;                   // Low sense resistor select
    logic [PORTS_P-1:0] overload_fault_flag_q;   // Sticky overload faults
    logic [PORTS_P-1:0] hard_limit_fault_flag_q; // Sticky hard-limit faults
    logic [PORTS_P-1:0] pwr_q;                   // Port power state
    logic [PORTS_P-1:0] ovl_exp;                 // Overload expiry this cycle
    logic [PORTS_P-1:0] lim_exp;                 // Hard-limit expiry this cycle
    poeoc_cfg_s         cfg [PORTS_P];           // Effective per-port settings

    // ------------------------------------------------------------------
    // Shared tick prescaler
    // ------------------------------------------------------------------
    logic [7:0] pre_q;    // Cycles within a tick
    logic [7:0] up_q;     // Ticks within an up step
    logic       tick;     // Decrement period strobe
    logic       up_tick;  // Slower increment strobe

    assign tick    = (pre_q == 8'(TICK_CYC - 1));
    assign up_tick = tick && (up_q == 8'(UP_RATIO_P - 1));

    // Prescaler and increment divider, free running
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= 8'h00;
            up_q  <= 8'h00;
        end else begin
            pre_q <= tick ? 8'h00 : pre_q + 8'h01;
            if (tick) begin
                up_q <= up_tick ? 8'h00 : up_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Configuration stores
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < PORTS_P; i++) thr_code_q[i] <= RST_THR[2:0];
            plus_q    <= '0;
            tim_ovl_q <= RST_TIMING[3:0];
            tim_lim_q <= RST_TIMING[7:4];
            auto_q    <= RST_GEN[GEN_AUTO_BIT];
            lsr_q     <= RST_GEN[GEN_LSR_BIT];
        end else if (reg_wr) begin
            if (reg_addr == ADDR_THR_LO) begin
                thr_code_q[0] <= reg_wdata[2:0];
                thr_code_q[1] <= reg_wdata[THR_FLD_W+2:THR_FLD_W];
            end else if (reg_addr == ADDR_THR_HI) begin
                thr_code_q[2] <= reg_wdata[2:0];
                thr_code_q[3] <= reg_wdata[THR_FLD_W+2:THR_FLD_W];
            end else if (reg_addr == ADDR_TIMING) begin
                tim_ovl_q <= reg_wdata[TIM_OVL_LSB+3:TIM_OVL_LSB];
                tim_lim_q <= reg_wdata[TIM_LIM_LSB+3:TIM_LIM_LSB];
            end else if (reg_addr == ADDR_PLUS) begin
                plus_q <= reg_wdata[PORTS_P-1:0];
            end else if (reg_addr == ADDR_GEN) begin
                auto_q <= reg_wdata[GEN_AUTO_BIT];
                lsr_q  <= reg_wdata[GEN_LSR_BIT];
            end
        end
    end

    // Write strobes for the event and power registers
    logic wr_fault;   // Clear overload flags
    logic wr_limevt;  // Clear hard-limit flags
    logic wr_power;   // Power request write
    assign wr_fault  = reg_wr && (reg_addr == ADDR_FAULT);
    assign wr_limevt = reg_wr && (reg_addr == ADDR_LIMEVT);
    assign wr_power  = reg_wr && (reg_addr == ADDR_POWER);

    // Sticky flags: an expiry in the clearing cycle still sets the flag
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            overload_fault_flag_q   <= '0;
            hard_limit_fault_flag_q <= '0;
        end else begin
            overload_fault_flag_q <= (overload_fault_flag_q
                & ~(wr_fault ? reg_wdata[PORTS_P-1:0] : '0)) | ovl_exp;
            hard_limit_fault_flag_q <= (hard_limit_fault_flag_q
                & ~(wr_limevt ? reg_wdata[PORTS_P-1:0] : '0)) | lim_exp;
        end
    end

    // Power state: host turns ports on or off, any expiry turns a port off
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pwr_q <= '0;
        end else begin
            pwr_q <= (wr_power ? reg_wdata[PORTS_P-1:0] : pwr_q) & ~(ovl_exp | lim_exp);
        end
    end

    // Register reads, data stand in the next cycle; unmapped reads zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_THR_LO) begin
                reg_rdata <= {1'b0, cfg[1].thr_code, 1'b0, cfg[0].thr_code};
            end else if (reg_addr == ADDR_THR_HI) begin
                reg_rdata <= {1'b0, cfg[3].thr_code, 1'b0, cfg[2].thr_code};
            end else if (reg_addr == ADDR_TIMING) begin
                reg_rdata <= {tim_lim_q, tim_ovl_q};
            end else if (reg_addr == ADDR_PLUS) begin
                reg_rdata <= DATA_W'(plus_q);
            end else if (reg_addr == ADDR_GEN) begin
                reg_rdata <= {6'h00, lsr_q, auto_q};
            end else if (reg_addr == ADDR_FAULT) begin
                reg_rdata <= DATA_W'(overload_fault_flag_q);
            end else if (reg_addr == ADDR_LIMEVT) begin
                reg_rdata <= DATA_W'(hard_limit_fault_flag_q);
            end else if (reg_addr == ADDR_POWER) begin
                reg_rdata <= DATA_W'(pwr_q);
            end else begin
                reg_rdata <= '0;
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Sense scaling output
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            low_sense_resistor_select <= 1'b0;
        end else begin
            low_sense_resistor_select <= lsr_q;
        end
    end

    // ------------------------------------------------------------------
    // Per-port timers
    // ------------------------------------------------------------------
    for (genvar p = 0; p < PORTS_P; p++) begin : g_port
        logic [CNT_W-1:0] ovl_q;      // Overload timeout counter
        logic [CNT_W-1:0] lim_q;      // Hard-limit timeout counter
        logic [CNT_W-1:0] ovl_max;    // Overload saturation count
        logic [CNT_W-1:0] lim_max;    // Hard-limit saturation count
        logic [9:0]       cur_ma;     // This port's current
        logic             over;       // Overload threshold reached
        logic             auto_plus;  // Plus selection in auto mode

        // Auto mode picks type 2 settings from classification
        assign auto_plus = class_valid[p] && class_plus[p];
        always_comb begin
            if (auto_q) begin
                cfg[p].plus     = auto_plus;
                cfg[p].thr_code = auto_plus ? 3'b110 : 3'b000;
            end else begin
                cfg[p].plus     = plus_q[p];
                cfg[p].thr_code = thr_code_q[p];
            end
        end

        // Timeout field n gives a full count of 16*n+15 ticks
        assign ovl_max = CNT_W'({tim_ovl_q, 4'hF});
        assign lim_max = CNT_W'({tim_lim_q, 4'hF});
        assign cur_ma  = port_current_ma[p*10 +: 10];
        assign over    = port_current_ma_valid[p]
                         && (cur_ma >= THR_MA[cfg[p].thr_code]);

        assign ovl_exp[p] = pwr_q[p] && !inrush_active[p] && over
                            && tick && (ovl_q == CNT_W'(1));
        assign lim_exp[p] = pwr_q[p] && hard_limit_hit[p]
                            && tick && (lim_q == CNT_W'(1));

        // Overload counter: fast down while over outside inrush, slow up otherwise
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                ovl_q <= {CNT_W{1'b1}};
            end else if (!pwr_q[p]) begin
                ovl_q <= ovl_max;                          // Reload while off
            end else if (over && !inrush_active[p]) begin
                if (tick && ovl_q != '0) ovl_q <= ovl_q - CNT_W'(1);
            end else if (up_tick && ovl_q < ovl_max) begin
                ovl_q <= ovl_q + CNT_W'(1);
            end else if (ovl_q > ovl_max) begin
                ovl_q <= ovl_max;                          // Field shrunk
            end
        end

        // Hard-limit counter, runs in inrush and powered phases
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                lim_q <= {CNT_W{1'b1}};
            end else if (!pwr_q[p]) begin
                lim_q <= lim_max;
            end else if (hard_limit_hit[p]) begin
                if (tick && lim_q != '0) lim_q <= lim_q - CNT_W'(1);
            end else if (up_tick && lim_q < lim_max) begin
                lim_q <= lim_q + CNT_W'(1);
            end else if (lim_q > lim_max) begin
                lim_q <= lim_max;
            end
        end

        // Analog controls: gate off on short or power off, curve select
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                gate_force_off[p] <= 1'b1;
                limit_curve_2x[p] <= 1'b0;
                limit_inrush[p]   <= 1'b0;
                port_power_en[p]  <= 1'b0;
            end else begin
                gate_force_off[p] <= short_detect[p] || !pwr_q[p];
                limit_inrush[p]   <= pwr_q[p] && inrush_active[p];
                limit_curve_2x[p] <= pwr_q[p] && !inrush_active[p]
                                     && power_good[p] && cfg[p].plus;
                port_power_en[p]  <= pwr_q[p] && !ovl_exp[p] && !lim_exp[p];
            end
        end
    end

endmodule : poeoc_top

/* core/poeoc_pkg.sv */
// Package for the per-port overcurrent timer block: register map, fields and timing.
package poeoc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int          PORTS        = 4;          // Ports supervised
    localparam int          CNT_W        = 8;          // Timeout counter width
    localparam int          ADDR_W       = 4;          // Register address width
    localparam int          DATA_W       = 8;          // Register data width

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0]  ADDR_THR_LO  = 4'h0;       // Threshold codes, ports 0 and 1
    localparam logic [3:0]  ADDR_THR_HI  = 4'h1;       // Threshold codes, ports 2 and 3
    localparam logic [3:0]  ADDR_TIMING  = 4'h2;       // Overload and hard-limit timeouts
    localparam logic [3:0]  ADDR_PLUS    = 4'h3;       // Plus-power select, one bit a port
    localparam logic [3:0]  ADDR_GEN     = 4'h4;       // Auto mode, sense resistor select
    localparam logic [3:0]  ADDR_FAULT   = 4'h5;       // Overload fault flags, write 1 clears
    localparam logic [3:0]  ADDR_LIMEVT  = 4'h6;       // Hard-limit fault flags, write 1 clears
    localparam logic [3:0]  ADDR_POWER   = 4'h7;       // Power enable request / state

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          THR_FLD_W    = 4;          // Each port takes one nibble
    localparam int          TIM_OVL_LSB  = 0;          // Overload timeout field
    localparam int          TIM_LIM_LSB  = 4;          // Hard-limit timeout field
    localparam int          GEN_AUTO_BIT = 0;          // Automatic mode
    localparam int          GEN_LSR_BIT  = 1;          // Low sense resistor select

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_THR      = 8'h00;      // Code 000: 374 mA nominal
    localparam logic [7:0]  RST_TIMING   = 8'h00;      // Shortest timeouts
    localparam logic [7:0]  RST_GEN      = 8'h01;      // Automatic mode as shipped

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_NS       = 100;        // Clock period in ns
    localparam int          TICK_NS      = 1000;       // Decrement period in ns
    localparam int          TICK_CYC     = (TICK_NS + CLK_NS - 1) / CLK_NS; // Cycles per tick
    localparam int          UP_RATIO     = 4;          // Decrement ticks per increment

    // Nominal thresholds in mA per 3-bit code
    typedef logic [9:0] poeoc_ma_t;
    localparam poeoc_ma_t THR_MA [8] = '{10'd374, 10'd110, 10'd204, 10'd374,
                                        10'd754, 10'd592, 10'd645, 10'd920};

    // Per-port configuration carried into the timer logic
    typedef struct packed {
        logic [2:0] thr_code;                          // Overload threshold code
        logic       plus;                              // Plus-power select
    } poeoc_cfg_s;

endpackage : poeoc_pkg

/* testbench/poeoc_properties.sv */
// Port-level assertions for the overcurrent timer block.
`timescale 1ns/1ps
module poeoc_checker
    import poeoc_pkg::*;
#(
    parameter int PORTS_P = 4                      // Number of ports
) (
    input wire logic               sys_clk,        // Clock
    input wire logic               resetn,         // Async reset, low
    input wire logic [3:0]         reg_addr,       // Register address
    input wire logic               reg_wr,         // Write strobe
    input wire logic               reg_rd,         // Read strobe
    input wire logic [7:0]         reg_rdata,      // Read data
    input wire logic [PORTS_P-1:0] short_detect,   // Short comparator
    input wire logic [PORTS_P-1:0] power_good,     // Power good
    input wire logic [PORTS_P-1:0] inrush_active,  // Start period
    input wire logic [PORTS_P-1:0] port_power_en,  // Port powered
    input wire logic [PORTS_P-1:0] gate_force_off, // Gate pulled off
    input wire logic [PORTS_P-1:0] limit_curve_2x, // Doubled curve
    input wire logic [PORTS_P-1:0] limit_inrush,   // Inrush profile
    input wire logic               low_sense_resistor_select // Scale
);
    // General register write, for $past
    logic gen_wr;
    assign gen_wr = reg_wr && (reg_addr == ADDR_GEN);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // ----
    // Sequences
    // ----
    sequence short_held0;
        short_detect[0] [*2];
    endsequence
    sequence power_up0;
        $rose(port_power_en[0]);
    endsequence

    // ----
    // Properties
    // ----
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside a read");
    chk_unmapped_rd: assert property (reg_rd && reg_addr[3] |=> reg_rdata == '0)
        else $error("unmapped read returned data");
    chk_curve_cause: assert property (
        (limit_curve_2x & ~$past(power_good & ~inrush_active)) == '0)
        else $error("doubled curve without power good");
    chk_curve_excl: assert property ((limit_curve_2x & limit_inrush) == '0)
        else $error("doubled curve during inrush");
    chk_inrush_cause: assert property ((limit_inrush & ~$past(inrush_active)) == '0)
        else $error("inrush profile outside start period");
    chk_short_gate: assert property (short_held0 |-> gate_force_off[0])
        else $error("gate not pulled off on short");
    chk_gate_unpowered: assert property (
        (~gate_force_off & ~port_power_en & ~$past(port_power_en)) == '0)
        else $error("gate released on unpowered port");
    chk_sense_write: assert property (
        $changed(low_sense_resistor_select) |-> $past(gen_wr) || $past(gen_wr, 2))
        else $error("sense scale changed without a write");
    chk_power_min_on: assert property (power_up0 |=> port_power_en[0] [*8])
        else $error("port dropped right after power up");
endmodule : poeoc_checker

bind poeoc_top poeoc_checker #(.PORTS_P(PORTS_P)) u_poeoc_checker (.sys_clk, .resetn, .reg_addr,
    .reg_wr, .reg_rd, .reg_rdata, .short_detect, .power_good, .inrush_active, .port_power_en,
    .gate_force_off, .limit_curve_2x, .limit_inrush, .low_sense_resistor_select);

/* testbench/poeoc_pd_model.sv */
// Behavioural model of four powered devices on the far side of the ports.
`timescale 1ns/1ps
module poeoc_pd_model #(
    parameter int INRUSH_CYC = 30                 // Start period in cycles, below 64
) (
    input  wire logic        sys_clk,             // Clock
    input  wire logic        resetn,              // Async reset, low
    input  wire logic [3:0]  port_power_en,       // Ports powered by the block
    input  wire logic [39:0] cur_cmd,             // Load current wanted, mA
    input  wire logic [3:0]  lim_cmd,             // Load pulls past foldback
    input  wire logic [3:0]  short_cmd,           // Load shorted
    input  wire logic [3:0]  plus_cmd,            // Device classifies as type 2
    output logic      [3:0]  port_current_ma_valid, // Measurement usable
    output logic      [39:0] port_current_ma,     // Measured current
    output logic      [3:0]  hard_limit_hit,      // Foldback reached
    output logic      [3:0]  short_detect,        // Short seen
    output logic      [3:0]  power_good,          // Output settled
    output logic      [3:0]  inrush_active,       // Charging input capacitance
    output logic      [3:0]  class_plus,          // Class result
    output logic      [3:0]  class_valid          // Class done
);
    logic [5:0] start_q [4];                      // Cycles since power up

    // Load reacts only while powered; an invalid reading shows junk, not 0
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            start_q <= '{default: '0};
            {port_current_ma_valid, hard_limit_hit, short_detect} <= '0;
            {power_good, inrush_active, class_plus, class_valid} <= '0;
            port_current_ma <= '0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (!port_power_en[p]) begin
                    start_q[p] <= '0;
                end else if (start_q[p] != 6'(INRUSH_CYC)) begin
                    start_q[p] <= start_q[p] + 6'd1;
                end
                inrush_active[p] <= port_power_en[p] && start_q[p] != 6'(INRUSH_CYC);
                power_good[p] <= port_power_en[p] && start_q[p] == 6'(INRUSH_CYC);
                port_current_ma[p*10+:10] <= port_power_en[p] ? cur_cmd[p*10+:10]
                                                             : ~port_current_ma[p*10+:10];
            end
            port_current_ma_valid <= port_power_en;
            hard_limit_hit <= port_power_en & lim_cmd;
            short_detect <= port_power_en & short_cmd;
            class_plus <= plus_cmd;
            class_valid <= 4'hF;
        end
    end
endmodule : poeoc_pd_model

/* testbench/poe_port_overcurrent_timers_tb.sv */
// Self-checking bench for the per-port overcurrent timer block.
`timescale 1ns/1ps
module poe_port_overcurrent_timers_tb;
    import poeoc_pkg::*;
    logic        sys_clk = 1'b0, resetn = 1'b0;   // 10 MHz clock; reset held low
    logic [3:0]  reg_addr = '0;                   // Register bus
    logic [7:0]  reg_wdata = '0, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [39:0] cur_cmd = '0;                    // Partner controls
    logic [3:0]  lim_cmd = '0, short_cmd = '0, plus_cmd = '0;
    logic [39:0] port_current_ma;
    logic [3:0]  port_current_ma_valid, hard_limit_hit, short_detect, power_good;
    logic [3:0]  inrush_active, class_plus, class_valid, port_power_en;
    logic [3:0]  gate_force_off, limit_curve_2x, limit_inrush;
    logic        low_sense_resistor_select;
    int          num_errors = 0;
    int          checks = 0;

    always #50 sys_clk = ~sys_clk;

    poeoc_top #(.PORTS_P(4), .UP_RATIO_P(UP_RATIO)) u_poeoc_top (.sys_clk, .resetn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_current_ma_valid, .port_current_ma,
        .hard_limit_hit, .short_detect, .power_good, .inrush_active, .class_plus, .class_valid,
        .port_power_en, .gate_force_off, .limit_curve_2x, .limit_inrush,
        .low_sense_resistor_select);
    poeoc_pd_model u_poeoc_pd_model (.sys_clk, .resetn, .port_power_en, .cur_cmd, .lim_cmd,
        .short_cmd, .plus_cmd, .port_current_ma_valid, .port_current_ma, .hard_limit_hit,
        .short_detect, .power_good, .inrush_active, .class_plus, .class_valid);

    // ----
    // Expectations and bus tasks
    // ----
    // Nominal threshold per code, kept apart from the design's table
    function automatic logic [9:0] thr_exp(input logic [2:0] c);
        logic [9:0] ma [8] = '{10'd374, 10'd110, 10'd204, 10'd374,
                               10'd754, 10'd592, 10'd645, 10'd920};
        return ma[c];
    endfunction : thr_exp

    task automatic wrap_up;
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One idle cycle between strobes keeps each driver edge single
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", reg_rdata, e);
    endtask : rdc

    // Bounded wait for a port to reach a power state
    task automatic wait_pwr(input int p, input logic v, input int bound);
        for (int n = 0; port_power_en[p] !== v; n++) begin
            if (n == bound) begin
                chk("power state", {7'h0, port_power_en[p]}, {7'h0, v});
                wrap_up();
            end
            @(posedge sys_clk);
        end
    endtask : wait_pwr

    // Port must survive min_cyc of fault, then drop within bound
    task automatic hold_on(input int p, input int min_cyc, input int bound);
        repeat (min_cyc) @(posedge sys_clk);
        chk("still powered", {7'h0, port_power_en[p]}, 8'h1);
        wait_pwr(p, 1'b0, bound);
    endtask : hold_on

    task automatic pwr_up(input int p);
        wr(ADDR_POWER, 8'(1 << p));
        wait_pwr(p, 1'b1, 5);
        repeat (40) @(posedge sys_clk);
    endtask : pwr_up

    // ----
    // Main sequence
    // ----
    initial begin
        logic [9:0] t;
        void'($urandom(32'hea4e6993));
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 9; a++) rdc(4'(a), (a == 4) ? 8'h01 : 8'h00);
        chk("gate off", {4'h0, gate_force_off}, 8'hF);
        plus_cmd <= 4'h1;
        repeat (3) @(posedge sys_clk);
        rdc(ADDR_THR_LO, 8'h06);
        wr(ADDR_POWER, 8'h01);
        wait_pwr(0, 1'b1, 5);
        repeat (5) @(posedge sys_clk);
        chk("inrush", {4'h0, limit_inrush}, 8'h1);
        chk("curve", {4'h0, limit_curve_2x}, 8'h0);
        repeat (40) @(posedge sys_clk);
        chk("curve", {4'h0, limit_curve_2x}, 8'h1);
        wr(ADDR_POWER, 8'h00);
        wr(ADDR_GEN, 8'h02);
        repeat (3) @(posedge sys_clk);
        chk("sense", {7'h0, low_sense_resistor_select}, 8'h1);
        for (int c = 0; c < 8; c++) begin
            t = thr_exp(3'(c));
            wr(ADDR_THR_LO, 8'(c));
            wr(ADDR_PLUS, 8'(c >> 2));
            pwr_up(0);
            chk("curve", {7'h0, limit_curve_2x[0]}, 8'(c >> 2));
            cur_cmd[9:0] <= 10'($urandom_range(t - 10'd1));
            repeat (200) @(posedge sys_clk);
            cur_cmd[9:0] <= t;
            hold_on(0, 130, 40);
            rdc(ADDR_FAULT, 8'h01);
            wr(ADDR_FAULT, 8'h01);
            rdc(ADDR_FAULT, 8'h00);
            wr(ADDR_POWER, 8'h00);
            cur_cmd[9:0] <= '0;
        end
        wr(ADDR_THR_LO, 8'h00);
        wr(ADDR_PLUS, 8'h00);
        pwr_up(0);
        cur_cmd[9:0] <= 10'd400;
        repeat (100) @(posedge sys_clk);
        cur_cmd[9:0] <= 10'd0;
        repeat (800) @(posedge sys_clk);
        cur_cmd[9:0] <= 10'd400;
        hold_on(0, 120, 60);
        cur_cmd[9:0] <= 10'd0;
        wr(ADDR_FAULT, 8'h01);
        wr(ADDR_POWER, 8'h00);
        wr(ADDR_TIMING, 8'h10);
        pwr_up(1);
        lim_cmd[1] <= 1'b1;
        hold_on(1, 290, 60);
        rdc(ADDR_LIMEVT, 8'h02);
        rdc(ADDR_FAULT, 8'h00);
        wr(ADDR_LIMEVT, 8'h02);
        rdc(ADDR_LIMEVT, 8'h00);
        lim_cmd[1] <= 1'b0;
        wr(ADDR_POWER, 8'h00);
        pwr_up(0);
        short_cmd[0] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("gate off", {7'h0, gate_force_off[0]}, 8'h1);
        chk("powered", {7'h0, port_power_en[0]}, 8'h1);
        short_cmd[0] <= 1'b0;
        wrap_up();
    end
endmodule : poe_port_overcurrent_timers_tb
